// File: design/msd_delay_manager.sv
// Purpose: Step timer, captures, compare, multiplier and motor input pin setup
// Assumes: z_event and d_event are one-cycle pulses from detection logic on pclk
// Notes:   APB answers with no wait states; writes to step_ratio_field are ignored while the timer runs
//
// Functional notes
// - PHASE_COMPARATOR_CONTROL=1, tacho 00, input select 11: pins standard I/O
// - Sensorless off pins: high-Z or ground per select
// - Analog input pin disables its port input
// - Digital sensor pin stays readable as port
// - Eight-bit timer, registers shift with prescaler
// - Two captures, demag register, multiplier, compare register
// - Mode select: 0 switched, 1 autoswitched
// - Autoswitched: hardware commutation from captures and registers
// - Simulated commutation compares written value with timer
// - Simulated: no compare until compare register written
// - Speed measurement mode never commutates
// - Switched: compare match commutates, clears timer
// - Commutation loads preloads, sets flag, interrupt
// - Switched: ratio flag steps prescaler at next commutation
// - Writing both ratio flags together is ignored
// - Switched: zero-cross and demag leave timer alone
// - Switched overflow restarts at zero, flag if tacho 00
// - Speed mode auto-updates prescaler from captures
// - Hardware zero-cross captures, cascades, clears timer
// - Compare gets weight times chosen capture over 256
`timescale 1ns/10ps
module msd_delay_manager
	import msd_pkg::*;
	#(
	parameter int PRESC_W = 16
	)
	(
	// Clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// APB slave
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Motor input pins and detection events
	input  wire logic [2:0]        motor_in,
	input  wire logic              z_event,
	input  wire logic              d_event,
	// Pin configuration and port readback
	output logic      [2:0]        pin_analog_en,
	output logic      [2:0]        pin_port_en,
	output logic      [2:0]        pin_gnd_oe,
	output logic      [2:0]        pin_alt_en,
	output logic      [2:0]        port_level,
	// Commutation
	output logic                   commutation_pulse,
	output logic                   commutation_irq,
	output logic      [5:0]        phase_pattern
	);

	logic [CTRL_W-1:0]  ctrl_q, ctrl_d;
	logic [3:0]         step_ratio_field_q, step_ratio_field_d;
	logic               commutation_flag_q, commutation_flag_d;
	logic               overflow_flag_q, overflow_flag_d;
	logic               ratio_increment_flag_q, ratio_increment_flag_d;
	logic               ratio_decrement_flag_q, ratio_decrement_flag_d;
	logic               commutation_irq_mask_q, commutation_irq_mask_d;
	logic [7:0]         commutation_compare_q, commutation_compare_d;
	logic [7:0]         step_timer_q, step_timer_d;
	logic [7:0]         zero_cross_capture_q, zero_cross_capture_d;
	logic [7:0]         prior_zero_cross_capture_q, prior_zero_cross_capture_d;
	logic [7:0]         demag_capture_compare_q, demag_capture_compare_d;
	logic [7:0]         phase_weight_register_q, phase_weight_register_d;
	logic [5:0]         preload_q, preload_d;
	logic [5:0]         phase_pattern_q, phase_pattern_d;
	logic               compare_armed_q, compare_armed_d;
	logic               mult_pending_q, mult_pending_d;
	logic [PRESC_W-1:0] presc_q, presc_d, presc_limit;
	logic               comm_pulse_q, comm_pulse_d, irq_q, irq_d;
	logic [31:0]        prdata_q, prdata_d, read_word;
	logic               pready_q, pready_d, pslverr_q, pslverr_d, unmapped;
	logic               comm_evt, tick, apb_wr, apb_setup, zs_write;
	logic               shift_r, shift_l, oi_set, rinc_set, rdec_set;
	logic [15:0]        product;
	logic [2:0]         pin_sync1_q, pin_sync2_q;
	logic [2:0]         ana_d, ana_q, port_d, port_q, gnd_d, gnd_q, alt_d, alt_q;
	logic [2:0]         level_d, level_q;
	msd_pin_mode_e      pin_mode [3];

	logic       timer_clk_enable, switch_mode_select, sim_commutation_enable;
	logic       phase_comparator_control, sensor_select, off_input_state_select;
	logic       capture_source_select;
	logic [1:0] tacho_edge_select, input_select;

	assign timer_clk_enable         = ctrl_q[CTL_TCKE];
	assign switch_mode_select       = ctrl_q[CTL_MODE];
	assign sim_commutation_enable   = ctrl_q[CTL_SIMC];
	assign phase_comparator_control = ctrl_q[CTL_PCMP];
	assign sensor_select            = ctrl_q[CTL_SENS];
	assign off_input_state_select   = ctrl_q[CTL_OFFST];
	assign tacho_edge_select        = ctrl_q[CTL_TACHO+1:CTL_TACHO];
	assign input_select             = ctrl_q[CTL_INSEL+1:CTL_INSEL];
	assign capture_source_select    = ctrl_q[CTL_CSRC];

	// Prescaler divides pclk by 2^ratio
	assign presc_limit = (PRESC_W'(1) << step_ratio_field_q) - PRESC_W'(1);
	assign tick        = timer_clk_enable && (presc_q == presc_limit);
	assign product     = phase_weight_register_q * (capture_source_select ?
		zero_cross_capture_q : prior_zero_cross_capture_q);
	assign apb_setup   = psel && !penable;
	assign apb_wr      = psel && penable && pready_q && pwrite;
	assign zs_write    = apb_wr && paddr == OFS_ZCAP && timer_clk_enable
		&& switch_mode_select && tacho_edge_select == TACHO_OFF;

	always_comb
	begin
		ctrl_d                     = ctrl_q;
		step_ratio_field_d         = step_ratio_field_q;
		commutation_flag_d         = commutation_flag_q;
		overflow_flag_d            = overflow_flag_q;
		ratio_increment_flag_d     = ratio_increment_flag_q;
		ratio_decrement_flag_d     = ratio_decrement_flag_q;
		commutation_irq_mask_d     = commutation_irq_mask_q;
		commutation_compare_d      = commutation_compare_q;
		step_timer_d               = step_timer_q;
		zero_cross_capture_d       = zero_cross_capture_q;
		prior_zero_cross_capture_d = prior_zero_cross_capture_q;
		demag_capture_compare_d    = demag_capture_compare_q;
		phase_weight_register_d    = phase_weight_register_q;
		preload_d                  = preload_q;
		phase_pattern_d            = phase_pattern_q;
		compare_armed_d            = compare_armed_q;
		mult_pending_d             = 1'b0;
		comm_evt                   = 1'b0;
		shift_r                    = 1'b0;
		shift_l                    = 1'b0;
		oi_set                     = 1'b0;
		rinc_set                   = 1'b0;
		rdec_set                   = 1'b0;
		presc_d = (!timer_clk_enable || tick) ? '0 : presc_q + PRESC_W'(1);

		if (timer_clk_enable)
		begin
			if (tick)
			begin
				if (step_timer_q == TMR_WRAP)
				begin
					if (tacho_edge_select == TACHO_OFF)
						oi_set = 1'b1;
					// Switched mode leaves the prescaler to software
					if ((switch_mode_select || tacho_edge_select != TACHO_OFF)
						&& step_ratio_field_q != RATIO_MAX)
					begin
						step_ratio_field_d = step_ratio_field_q + 4'h1;
						step_timer_d       = TMR_MEDIAN;
						shift_r            = 1'b1;
						rinc_set           = (tacho_edge_select == TACHO_OFF);
					end
					else
						step_timer_d = REG8_RST;
				end
				else
					step_timer_d = step_timer_q + 8'h01;
			end

			// Zero-cross only touches the timer outside switched mode
			if ((tacho_edge_select != TACHO_OFF || switch_mode_select)
				&& (z_event || zs_write))
			begin
				prior_zero_cross_capture_d = zs_write ? pwdata[7:0] : zero_cross_capture_q;
				zero_cross_capture_d       = zs_write ? pwdata[7:0] : step_timer_q;
				step_timer_d               = REG8_RST;
				if (z_event && step_timer_q < TMR_SPEEDUP && step_ratio_field_q != RATIO_MIN)
				begin
					step_ratio_field_d = step_ratio_field_q - 4'h1;
					shift_l            = 1'b1;
					rdec_set           = (tacho_edge_select == TACHO_OFF);
				end
			end

			if (d_event)
				demag_capture_compare_d = step_timer_q;

			if (tacho_edge_select == TACHO_OFF)
			begin
				if (!switch_mode_select)
				begin
					if (tick && compare_armed_q && step_timer_q == commutation_compare_q)
					begin
						comm_evt     = 1'b1;
						step_timer_d = REG8_RST;
					end
				end
				else if (mult_pending_q && !sim_commutation_enable)
				begin
					commutation_compare_d = product[15:8];
					compare_armed_d       = 1'b1;
				end
				else if (compare_armed_q && commutation_compare_q <= step_timer_q)
				begin
					// Late result: commutate now and record the actual time
					comm_evt              = 1'b1;
					commutation_compare_d = step_timer_q;
				end
			end
		end

		// Hardware recomputes its own compare; a simulated one needs a new write
		if (comm_evt && (switch_mode_select || sim_commutation_enable))
			compare_armed_d = 1'b0;

		if (comm_evt)
		begin
			if (!switch_mode_select && ratio_increment_flag_q && step_ratio_field_q != RATIO_MAX)
			begin
				step_ratio_field_d = step_ratio_field_q + 4'h1;
				shift_r            = 1'b1;
			end
			else if (!switch_mode_select && ratio_decrement_flag_q
				&& step_ratio_field_q != RATIO_MIN)
			begin
				step_ratio_field_d = step_ratio_field_q - 4'h1;
				shift_l            = 1'b1;
			end
			ratio_increment_flag_d = 1'b0;
			ratio_decrement_flag_d = 1'b0;
			commutation_flag_d     = 1'b1;
			phase_pattern_d        = preload_q;
		end

		if (shift_r)
		begin
			zero_cross_capture_d       = {1'b0, zero_cross_capture_d[7:1]};
			prior_zero_cross_capture_d = {1'b0, prior_zero_cross_capture_d[7:1]};
			commutation_compare_d      = {1'b0, commutation_compare_d[7:1]};
			demag_capture_compare_d    = {1'b0, demag_capture_compare_d[7:1]};
		end
		if (shift_l)
		begin
			zero_cross_capture_d       = {zero_cross_capture_d[6:0], 1'b0};
			prior_zero_cross_capture_d = {prior_zero_cross_capture_d[6:0], 1'b0};
			commutation_compare_d      = {commutation_compare_d[6:0], 1'b0};
			demag_capture_compare_d    = {demag_capture_compare_d[6:0], 1'b0};
		end
		if (switch_mode_select && !sim_commutation_enable
			&& (z_event || zs_write || shift_r || shift_l))
			mult_pending_d = timer_clk_enable && tacho_edge_select == TACHO_OFF;

		if (oi_set)
			overflow_flag_d = 1'b1;
		if (rinc_set)
			ratio_increment_flag_d = 1'b1;
		if (rdec_set)
			ratio_decrement_flag_d = 1'b1;

		if (apb_wr)
		begin
			case (paddr)
				OFS_CTRL:    ctrl_d = pwdata[CTRL_W-1:0];
				OFS_RATIO:   if (!timer_clk_enable) step_ratio_field_d = pwdata[3:0];
				OFS_STAT:
				begin
					// Hardware set wins over a same-cycle clear
					if (pwdata[STAT_COMM] && !comm_evt)
						commutation_flag_d = 1'b0;
					if (pwdata[STAT_OVF] && !oi_set)
						overflow_flag_d = 1'b0;
					if (pwdata[STAT_RINC] != pwdata[STAT_RDEC])
					begin
						ratio_increment_flag_d = ratio_increment_flag_d | pwdata[STAT_RINC];
						ratio_decrement_flag_d = ratio_decrement_flag_d | pwdata[STAT_RDEC];
					end
				end
				OFS_MASK:    commutation_irq_mask_d = pwdata[0];
				OFS_COMP:
				begin
					commutation_compare_d = pwdata[7:0];
					compare_armed_d       = 1'b1;
				end
				OFS_ZCAP:    zero_cross_capture_d = pwdata[7:0];
				OFS_DEMAG:   demag_capture_compare_d = pwdata[7:0];
				OFS_WGHT:    phase_weight_register_d = pwdata[7:0];
				OFS_PRELOAD: preload_d = pwdata[5:0];
				default:     ;
			endcase
		end

		comm_pulse_d = comm_evt;
		irq_d        = commutation_flag_d && commutation_irq_mask_d;
	end

	// APB read mux and answer
	always_comb
	begin
		unmapped  = 1'b0;
		read_word = 32'h0000_0000;
		case (paddr)
			OFS_CTRL:    read_word[CTRL_W-1:0] = ctrl_q;
			OFS_RATIO:   read_word[3:0] = step_ratio_field_q;
			OFS_STAT:    read_word[3:0] = {ratio_decrement_flag_q, ratio_increment_flag_q,
				overflow_flag_q, commutation_flag_q};
			OFS_MASK:    read_word[0] = commutation_irq_mask_q;
			OFS_COMP:    read_word[7:0] = commutation_compare_q;
			OFS_TIMER:   read_word[7:0] = step_timer_q;
			OFS_ZCAP:    read_word[7:0] = zero_cross_capture_q;
			OFS_ZPRV:    read_word[7:0] = prior_zero_cross_capture_q;
			OFS_DEMAG:   read_word[7:0] = demag_capture_compare_q;
			OFS_WGHT:    read_word[7:0] = phase_weight_register_q;
			OFS_PRELOAD: read_word[5:0] = preload_q;
			default:     unmapped = 1'b1;
		endcase
		pready_d  = apb_setup;
		pslverr_d = apb_setup && unmapped;
		prdata_d  = apb_setup ? read_word : prdata_q;
	end

	// Motor input pin roles
	for (genvar i = 0; i < 3; i++)
	begin : g_pin
		assign pin_mode[i] = msd_pin_mode(phase_comparator_control, sensor_select,
			tacho_edge_select, input_select, 2'(i));
	end

	always_comb
	begin
		for (int i = 0; i < 3; i++)
		begin
			ana_d[i]  = (pin_mode[i] == PM_ANALOG);
			port_d[i] = (pin_mode[i] == PM_DIGITAL) || (pin_mode[i] == PM_STDIO);
			alt_d[i]  = (pin_mode[i] == PM_ANALOG) || (pin_mode[i] == PM_DIGITAL);
			gnd_d[i]  = (pin_mode[i] == PM_OFF) && off_input_state_select;
		end
		level_d = pin_sync2_q & port_d;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin_sync1_q <= 3'h0;
			pin_sync2_q <= 3'h0;
			ana_q       <= 3'h0;
			port_q      <= 3'h0;
			gnd_q       <= 3'h0;
			alt_q       <= 3'h0;
			level_q     <= 3'h0;
		end
		else
		begin
			pin_sync1_q <= motor_in;
			pin_sync2_q <= pin_sync1_q;
			ana_q       <= ana_d;
			port_q      <= port_d;
			gnd_q       <= gnd_d;
			alt_q       <= alt_d;
			level_q     <= level_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_q                     <= CTRL_RST;
			step_ratio_field_q         <= RATIO_RST;
			commutation_flag_q         <= 1'b0;
			overflow_flag_q            <= 1'b0;
			ratio_increment_flag_q     <= 1'b0;
			ratio_decrement_flag_q     <= 1'b0;
			commutation_irq_mask_q     <= 1'b0;
			commutation_compare_q      <= REG8_RST;
			step_timer_q               <= REG8_RST;
			zero_cross_capture_q       <= REG8_RST;
			prior_zero_cross_capture_q <= REG8_RST;
			demag_capture_compare_q    <= REG8_RST;
			phase_weight_register_q    <= REG8_RST;
			preload_q                  <= PHASE_RST;
			phase_pattern_q            <= PHASE_RST;
			compare_armed_q            <= 1'b0;
			mult_pending_q             <= 1'b0;
			presc_q                    <= '0;
			comm_pulse_q               <= 1'b0;
			irq_q                      <= 1'b0;
			prdata_q                   <= 32'h0000_0000;
			pready_q                   <= 1'b0;
			pslverr_q                  <= 1'b0;
		end
		else
		begin
			ctrl_q                     <= ctrl_d;
			step_ratio_field_q         <= step_ratio_field_d;
			commutation_flag_q         <= commutation_flag_d;
			overflow_flag_q            <= overflow_flag_d;
			ratio_increment_flag_q     <= ratio_increment_flag_d;
			ratio_decrement_flag_q     <= ratio_decrement_flag_d;
			commutation_irq_mask_q     <= commutation_irq_mask_d;
			commutation_compare_q      <= commutation_compare_d;
			step_timer_q               <= step_timer_d;
			zero_cross_capture_q       <= zero_cross_capture_d;
			prior_zero_cross_capture_q <= prior_zero_cross_capture_d;
			demag_capture_compare_q    <= demag_capture_compare_d;
			phase_weight_register_q    <= phase_weight_register_d;
			preload_q                  <= preload_d;
			phase_pattern_q            <= phase_pattern_d;
			compare_armed_q            <= compare_armed_d;
			mult_pending_q             <= mult_pending_d;
			presc_q                    <= presc_d;
			comm_pulse_q               <= comm_pulse_d;
			irq_q                      <= irq_d;
			prdata_q                   <= prdata_d;
			pready_q                   <= pready_d;
			pslverr_q                  <= pslverr_d;
		end
	end

	assign prdata            = prdata_q;
	assign pready            = pready_q;
	assign pslverr           = pslverr_q;
	assign pin_analog_en     = ana_q;
	assign pin_port_en       = port_q;
	assign pin_gnd_oe        = gnd_q;
	assign pin_alt_en        = alt_q;
	assign port_level        = level_q;
	assign commutation_pulse = comm_pulse_q;
	assign commutation_irq   = irq_q;
	assign phase_pattern     = phase_pattern_q;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_pin_release: assert property (
		phase_comparator_control && tacho_edge_select == TACHO_OFF && input_select == INSEL_NONE
		|=> pin_alt_en == 3'h0 && pin_port_en == 3'h7)
		else $error("motor inputs not released as standard I/O");
	chk_off_state: assert property (
		!phase_comparator_control && tacho_edge_select == TACHO_OFF && !sensor_select
		&& input_select == 2'h0 |=> pin_gnd_oe == {{2{$past(off_input_state_select)}}, 1'b0})
		else $error("unused input off state wrong");
	chk_analog_port: assert property ((pin_analog_en & pin_port_en) == 3'h0)
		else $error("analog pin kept its port input");
	chk_port_readback: assert property (
		pin_alt_en[0] && !pin_analog_en[0] |-> pin_port_en[0])
		else $error("digital sensor pin not readable");
	chk_switched_commute: assert property (
		!switch_mode_select && tacho_edge_select == TACHO_OFF && tick && compare_armed_q
		&& step_timer_q == commutation_compare_q |=> step_timer_q == 8'h00 && commutation_pulse
		##1 !commutation_pulse)
		else $error("switched compare match did not commutate");
	chk_comm_preload: assert property (
		commutation_pulse |-> phase_pattern == $past(preload_q) && commutation_flag_q
		&& (commutation_irq == commutation_irq_mask_q))
		else $error("commutation side effects missing");
	chk_unwritten_idle: assert property (
		sim_commutation_enable && !compare_armed_q |=> !commutation_pulse)
		else $error("simulated commutation without compare write");
	chk_ratio_both: assert property (
		apb_wr && paddr == OFS_STAT && pwdata[STAT_RINC] && pwdata[STAT_RDEC]
		&& !comm_evt && !switch_mode_select |=> ratio_increment_flag_q == $past(ratio_increment_flag_q)
		&& ratio_decrement_flag_q == $past(ratio_decrement_flag_q))
		else $error("double ratio write changed flags");
	chk_ratio_step: assert property (
		comm_evt && !switch_mode_select && ratio_increment_flag_q && !apb_wr
		&& step_ratio_field_q != RATIO_MAX |=> step_ratio_field_q == $past(step_ratio_field_q) + 4'h1
		&& !ratio_increment_flag_q)
		else $error("ratio increment not applied at commutation");
	chk_speed_no_comm: assert property (tacho_edge_select != TACHO_OFF |=> !commutation_pulse)
		else $error("commutation in speed measurement mode");
	chk_switched_wrap: assert property (
		tick && !switch_mode_select && tacho_edge_select == TACHO_OFF && step_timer_q == TMR_WRAP
		&& !comm_evt |=> step_timer_q == 8'h00 && overflow_flag_q)
		else $error("switched overflow handling wrong");

	cov_switched_comm: cover property (commutation_pulse && !switch_mode_select);
	cov_auto_comm: cover property (commutation_pulse && switch_mode_select);
	cov_auto_speedup: cover property (ratio_decrement_flag_q && switch_mode_select);
	cov_overflow: cover property (overflow_flag_q);
endmodule

// File: design/msd_pkg.sv
// Purpose: Shared constants, types and pin decode for the motor step delay manager
// Assumes: APB slave with 32-bit data, one register per aligned word
// Notes:   Motor input index 0, 1, 2 stands for motor_input_a, _b, _c
package msd_pkg;
	localparam int ADDR_W = 6;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL    = 6'h00;
	localparam logic [ADDR_W-1:0] OFS_RATIO   = 6'h04;
	localparam logic [ADDR_W-1:0] OFS_STAT    = 6'h08;
	localparam logic [ADDR_W-1:0] OFS_MASK    = 6'h0C;
	localparam logic [ADDR_W-1:0] OFS_COMP    = 6'h10;
	localparam logic [ADDR_W-1:0] OFS_TIMER   = 6'h14;
	localparam logic [ADDR_W-1:0] OFS_ZCAP    = 6'h18;
	localparam logic [ADDR_W-1:0] OFS_ZPRV    = 6'h1C;
	localparam logic [ADDR_W-1:0] OFS_DEMAG   = 6'h20;
	localparam logic [ADDR_W-1:0] OFS_WGHT    = 6'h24;
	localparam logic [ADDR_W-1:0] OFS_PRELOAD = 6'h28;

	// Control register fields
	localparam int CTL_TCKE  = 0;
	localparam int CTL_MODE  = 1;
	localparam int CTL_SIMC  = 2;
	localparam int CTL_PCMP  = 3;
	localparam int CTL_SENS  = 4;
	localparam int CTL_OFFST = 5;
	localparam int CTL_TACHO = 6;
	localparam int CTL_INSEL = 8;
	localparam int CTL_CSRC  = 10;
	localparam int CTRL_W    = 11;

	// Status register fields
	localparam int STAT_COMM = 0;
	localparam int STAT_OVF  = 1;
	localparam int STAT_RINC = 2;
	localparam int STAT_RDEC = 3;

	// Reset values and limits
	localparam logic [CTRL_W-1:0] CTRL_RST    = 11'h000;
	localparam logic [3:0]        RATIO_RST   = 4'h0;
	localparam logic [3:0]        RATIO_MAX   = 4'hF;
	localparam logic [3:0]        RATIO_MIN   = 4'h0;
	localparam logic [7:0]        REG8_RST    = 8'h00;
	localparam logic [7:0]        TMR_WRAP    = 8'hFF;
	localparam logic [7:0]        TMR_MEDIAN  = 8'h80;
	localparam logic [7:0]        TMR_SPEEDUP = 8'h55;
	localparam logic [5:0]        PHASE_RST   = 6'h00;
	localparam logic [1:0]        TACHO_OFF   = 2'h0;
	localparam logic [1:0]        INSEL_NONE  = 2'h3;

	typedef enum logic [1:0] {PM_OFF, PM_ANALOG, PM_DIGITAL, PM_STDIO} msd_pin_mode_e;

	// Role of one motor input pin for a given input configuration
	function automatic msd_pin_mode_e msd_pin_mode(input logic pcmp, input logic sens,
		input logic [1:0] tacho, input logic [1:0] insel, input logic [1:0] idx);
		logic sel;
		sel = (insel == idx);
		if (tacho != TACHO_OFF)
			return (sel || (insel == INSEL_NONE && idx != 2'h2)) ? PM_DIGITAL : PM_STDIO;
		if (pcmp)
			return sel ? PM_ANALOG : PM_STDIO;
		if (sens)
			return sel ? PM_DIGITAL : PM_STDIO;
		return sel ? PM_ANALOG : PM_OFF;
	endfunction
endpackage

// File: sim/msd_motor_model.sv
// Purpose: Motor side model driving sensor levels and zero-cross pulses
// Assumes: Levels change only when the bench asks
// Notes:   Demag pulse trails each zero-cross by one cycle
`timescale 1ns/10ps
module msd_motor_model
	(
	// Clock and bench commands
	input  wire logic       pclk,
	input  wire logic [2:0] lvl,
	input  wire logic       zx_req,
	// Sensor side
	output logic      [2:0] motor_in,
	output logic            z_event,
	output logic            d_event
	);
	always_ff @(posedge pclk)
	begin
		motor_in <= lvl;
		z_event  <= zx_req;
		d_event  <= z_event;
	end
endmodule

// File: sim/tb.sv
// Purpose: Self-checking bench for the motor step delay manager
// Assumes: Pin outputs settle within five cycles of a change
// Notes:   Every wait is bounded and a hang ends the run
`timescale 1ns/10ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_fail++; \
	$display("[ERR] %0t mismatch got %0h want %0h", $time, a, e); end end
`define W(a, d) apb(1'b1, a, d);
`define R(a) apb(1'b0, a, 32'h0);
module tb
	import msd_pkg::*;
	;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, hit, zx_req;
	logic        commutation_pulse, commutation_irq, z_event, d_event;
	logic [5:0]  paddr, phase_pattern;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0]  lvl, motor_in, pin_analog_en, pin_port_en, pin_gnd_oe, pin_alt_en, port_level;
	int          n_fail, n_tests;
	msd_delay_manager u_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
		.prdata, .pready, .pslverr, .motor_in, .z_event, .d_event, .pin_analog_en,
		.pin_port_en, .pin_gnd_oe, .pin_alt_en, .port_level, .commutation_pulse,
		.commutation_irq, .phase_pattern);
	msd_motor_model u_motor (.pclk, .lvl, .zx_req, .motor_in, .z_event, .d_event);
	initial
	begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	task give_verdict;
		$display("tests %0d fails %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task expire(input logic ok);
		`CHK(ok, 1'b1)
		if (ok !== 1'b1)
			give_verdict;
	endtask
	// A leading edge keeps psel from being assigned twice in one step
	task apb(input logic w, input logic [5:0] a, input logic [31:0] wd);
		int i;
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, wd};
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20 && pready !== 1'b1; i++)
			@(posedge pclk);
		expire(pready === 1'b1);
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task wait_comm(input int n);
		int i;
		hit = 1'b0;
		for (i = 0; i < n && hit !== 1'b1; i++)
		begin
			@(posedge pclk);
			hit = commutation_pulse;
		end
	endtask
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, zx_req} <= '0;
		lvl     <= 3'b111;
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		repeat (5) @(posedge pclk);
		`CHK({pin_analog_en, port_level[0], pin_gnd_oe}, 7'h10)
		`R(OFS_STAT)
		`CHK(rd[3:0], 4'h0)
		`W(OFS_CTRL, 32'h20)
		repeat (2) @(posedge pclk);
		`CHK(pin_gnd_oe, 3'b110)
		lvl <= 3'b101;
		`W(OFS_CTRL, 32'h308)
		repeat (5) @(posedge pclk);
		`CHK({pin_alt_en, pin_port_en, port_level}, 9'h03D)
		lvl <= 3'b010;
		// Comparator goes off before the input select moves
		`W(OFS_CTRL, 32'h300)
		`W(OFS_CTRL, 32'h110)
		repeat (5) @(posedge pclk);
		`CHK({pin_alt_en, port_level}, 6'h12)
		$display("pin role test done");
		`W(OFS_STAT, 32'hC)
		`R(OFS_STAT)
		`CHK(rd[3:2], 2'b00)
		`R(6'h3C)
		`CHK(err, 1'b1)
		$display("flag and decode test done");
		zx_req <= 1'b1;
		@(posedge pclk);
		zx_req <= 1'b0;
		`W(OFS_CTRL, 32'h5)
		wait_comm(300);
		`CHK(hit, 1'b0)
		`R(OFS_STAT)
		`CHK(rd[1], 1'b1)
		`W(OFS_CTRL, 32'h0)
		`W(OFS_COMP, 32'h10)
		`W(OFS_MASK, 32'h1)
		`W(OFS_PRELOAD, 32'h2A)
		`W(OFS_STAT, 32'h3)
		`W(OFS_CTRL, 32'h1)
		// Timer resumes above the compare value, so it must wrap first
		wait_comm(300);
		expire(hit);
		@(posedge pclk);
		`CHK({commutation_irq, phase_pattern}, 7'h6A)
		`R(OFS_TIMER)
		`CHK(rd[7:0] < 8'h08, 1'b1)
		`W(OFS_STAT, 32'h4)
		wait_comm(100);
		expire(hit);
		`R(OFS_RATIO)
		`CHK(rd[3:0], 4'h1)
		`R(OFS_STAT)
		`CHK(rd[2], 1'b0)
		$display("commutation test done");
		`W(OFS_CTRL, 32'h0)
		`W(OFS_RATIO, 32'h0)
		`W(OFS_WGHT, 32'h80)
		`W(OFS_CTRL, 32'h403)
		`W(OFS_ZCAP, 32'h40)
		`R(OFS_ZPRV)
		`CHK(rd[7:0], 8'h40)
		`R(OFS_COMP)
		`CHK(rd[7:0], 8'h20)
		wait_comm(100);
		expire(hit);
		$display("autoswitched test done");
		give_verdict;
	end
endmodule
